// file: verilog/cc_pkg.sv
// shared constants, types and decode helpers of the capture/compare unit
package cc_pkg;

   // ----------------------------------------------------------------
   // register map: index and word byte address (index times four)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_FLAG = 8'h0c;
   localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
   localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
   localparam logic [7:0] IDX_CONTROL = 8'h17;
   localparam int unsigned ADDR_W = 10;
   localparam logic [9:0] ADDR_FLAG = {IDX_FLAG, 2'b00};
   localparam logic [9:0] ADDR_VALUE_LOW = {IDX_VALUE_LOW, 2'b00};
   localparam logic [9:0] ADDR_VALUE_HIGH = {IDX_VALUE_HIGH, 2'b00};
   localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned FLAG_BIT = 2;
   localparam int unsigned CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // mode field codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;

   // ----------------------------------------------------------------
   // capture prescaler counts
   // ----------------------------------------------------------------
   localparam logic [3:0] PRESC_RESET = 4'h0;
   localparam logic [3:0] PRESC_DIV4_LAST = 4'h3;
   localparam logic [3:0] PRESC_DIV16_LAST = 4'hf;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WDATA = 3'b010,
      BUS_RWAIT = 3'b100
   } cc_bus_state_type;

   typedef struct packed {
      logic level;
      logic drive_n;
   } cc_pin_out_type;

   typedef struct packed {
      logic timer_reset;
      logic adc_start;
   } cc_trigger_type;

   typedef struct packed {
      cc_bus_state_type bus;
      logic [9:0] addr;
      logic hit;
      logic [5:0] control;
      logic [15:0] value;
      logic flag;
      logic compare_latch;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      cc_pin_out_type pin;
      cc_trigger_type trig;
   } cc_state_type;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   function automatic logic cc_is_capture(input logic [3:0] mode);
      return mode[3:2] == 2'b01;
   endfunction

   function automatic logic cc_is_compare(input logic [3:0] mode);
      return mode[3:2] == 2'b10;
   endfunction

endpackage

// file: verilog/cc_edge_prescale.sv
// edge detector and capture event prescaler
`timescale 1ns/1ps
module cc_edge_prescale
   (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic level,
   input wire logic [3:0] mode,
   output logic capture_event
   );
   import cc_pkg::*;

   typedef struct packed {
      logic prev;
      logic [3:0] count;
   } cc_presc_state_type;

   cc_presc_state_type s;
   cc_presc_state_type next_s;

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   always_comb begin
      logic rise;
      logic fall;
      logic [3:0] last;
      rise = level & ~s.prev;
      fall = ~level & s.prev;
      last = (mode == MODE_CAP_RISE4) ? PRESC_DIV4_LAST : PRESC_DIV16_LAST;
      next_s = s;
      next_s.prev = level;
      capture_event = 1'b0;
      if (!cc_is_capture(mode)) begin
         next_s.count = PRESC_RESET;
      end else begin
         case (mode)
            MODE_CAP_FALL: begin
               capture_event = fall;
            end
            MODE_CAP_RISE: begin
               capture_event = rise;
            end
            MODE_CAP_RISE4, MODE_CAP_RISE16: begin
               // count survives a prescale change, so >= catches a count past the end
               if (rise) begin
                  if (s.count >= last) begin
                     capture_event = 1'b1;
                     next_s.count = PRESC_RESET;
                  end else begin
                     next_s.count = s.count + 4'h1;
                  end
               end
            end
            default: begin
               capture_event = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{prev: 1'b0, count: PRESC_RESET};
      end else begin
         s <= next_s;
      end
   end

endmodule

// file: verilog/cc_compare_match.sv
// value against timer comparator, one pulse per entry into equality
`timescale 1ns/1ps
module cc_compare_match
   (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic [15:0] value,
   input wire logic [15:0] timer_count,
   output logic match_event
   );
   import cc_pkg::*;

   typedef struct packed {
      logic equal_prev;
   } cc_match_state_type;

   cc_match_state_type s;
   cc_match_state_type next_s;

   // ----------------------------------------------------------------
   // compare every cycle
   // ----------------------------------------------------------------
   // a timer held on the value must not fire again each cycle
   always_comb begin
      logic equal;
      equal = enable && (value == timer_count);
      next_s.equal_prev = equal;
      match_event = equal & ~s.equal_prev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{equal_prev: 1'b0};
      end else begin
         s <= next_s;
      end
   end

endmodule

// file: verilog/cc_unit.sv
// capture/compare unit with ahb-lite register slave
// ----------------------------------------------------------------
// Overview of operation
// - a capture event copies the full 16-bit timer count into the value pair
// - mode 0100 captures on every falling pin edge
// - every capture sets flag bit 2; only software clears it
// - a newer capture overwrites an unread value
// - prescaler cleared when off, outside capture modes, and on reset
// - switching prescale directly keeps the counter; early capture possible
// - a mode change may set the flag falsely; not suppressed
// - with the pin as output, a port latch write can cause a capture
// - mode 0000 turns the unit off and clears prescaler and compare latch; flag and value pair keep their contents
// - compare modes match the value pair against the timer every cycle
// - mode 1000: match drives pin high and sets the flag
// - mode 1001: match drives pin low and sets the flag
// - mode 1010: match only sets the flag, pin untouched
// - mode 1011: match sets flag, resets timer, starts enabled conversion
// - pin action and flag setting come from the same match together
// - control bits 7-6 read zero; bits 5-4 duty bits without effect here
// - value low and high bytes and control are readable and writable
// ----------------------------------------------------------------
`timescale 1ns/1ps
module cc_unit
   (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [15:0] timer_count,
   input wire logic adc_enable,
   input wire logic pin_in,
   input wire logic pin_dir_in,
   input wire logic port_latch,
   output cc_pkg::cc_pin_out_type pin_out,
   output cc_pkg::cc_trigger_type trigger,
   output logic unit_irq_flag
   );
   import cc_pkg::*;

   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   cc_state_type s;
   cc_state_type next_s;
   logic [3:0] mode;
   logic sensed_level;
   logic capture_event;
   logic match_event;
   logic accept;

   localparam cc_state_type STATE_RESET = '{
      bus: BUS_IDLE,
      addr: '0,
      hit: 1'b0,
      control: CTRL_RESET,
      value: VALUE_RESET,
      flag: 1'b0,
      compare_latch: 1'b0,
      rdata: RDATA_RESET,
      ready: 1'b1,
      resp: 1'b0,
      pin: '{level: 1'b0, drive_n: 1'b1},
      trig: '{timer_reset: 1'b0, adc_start: 1'b0}
   };

   // register read view; reserved and unmapped words read zero
   function automatic logic [31:0] read_word(input logic hit, input logic [9:0] addr,
                                            input cc_state_type st);
      logic [31:0] word;
      word = 32'h0000_0000;
      if (hit) begin
         case (addr)
            ADDR_FLAG: begin
               word[FLAG_BIT] = st.flag;
            end
            ADDR_VALUE_LOW: begin
               word[7:0] = st.value[7:0];
            end
            ADDR_VALUE_HIGH: begin
               word[7:0] = st.value[15:8];
            end
            ADDR_CONTROL: begin
               word[5:0] = st.control;
            end
            default: begin
               word = 32'h0000_0000;
            end
         endcase
      end
      return word;
   endfunction

   assign mode = s.control[3:0];
   assign accept = hsel & htrans[1] & hready;

   // ----------------------------------------------------------------
   // pin sensing
   // ----------------------------------------------------------------
   // an output pin is sensed from what drives it, so latch writes look like edges
   always_comb begin
      if (pin_dir_in) begin
         sensed_level = pin_in;
      end else if (cc_is_compare(mode)) begin
         sensed_level = s.compare_latch;
      end else begin
         sensed_level = port_latch;
      end
   end

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   cc_edge_prescale u_edge_prescale (
      .hclk(hclk),
      .hresetn(hresetn),
      .level(sensed_level),
      .mode(mode),
      .capture_event(capture_event)
   );

   cc_compare_match u_compare_match (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(cc_is_compare(mode)),
      .value(s.value),
      .timer_count(timer_count),
      .match_event(match_event)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.resp = 1'b0;
      next_s.trig = '{timer_reset: 1'b0, adc_start: 1'b0};

      // bus: writes land at the end of their data phase
      case (s.bus)
         BUS_IDLE, BUS_WDATA: begin
            if (s.bus == BUS_WDATA && s.hit) begin
               case (s.addr)
                  ADDR_FLAG: begin
                     next_s.flag = hwdata[FLAG_BIT];
                  end
                  ADDR_VALUE_LOW: begin
                     next_s.value[7:0] = hwdata[7:0];
                  end
                  ADDR_VALUE_HIGH: begin
                     next_s.value[15:8] = hwdata[7:0];
                  end
                  ADDR_CONTROL: begin
                     next_s.control = hwdata[5:0];
                  end
                  default: begin
                     next_s.control = s.control;
                  end
               endcase
            end
            next_s.bus = BUS_IDLE;
            next_s.ready = 1'b1;
            if (accept) begin
               next_s.addr = haddr[9:0];
               next_s.hit = (haddr[31:10] == 22'h00_0000);
               if (hwrite) begin
                  next_s.bus = BUS_WDATA;
               end else begin
                  // one wait state so a read sees a write that just landed
                  next_s.bus = BUS_RWAIT;
                  next_s.ready = 1'b0;
               end
            end
         end
         BUS_RWAIT: begin
            next_s.rdata = read_word(s.hit, s.addr, s);
            next_s.ready = 1'b1;
            next_s.bus = BUS_IDLE;
         end
         default: begin
            next_s.bus = BUS_IDLE;
            next_s.ready = 1'b1;
         end
      endcase

      // capture: hardware wins over a same-cycle value write
      if (capture_event) begin
         next_s.value = timer_count;
         next_s.flag = 1'b1;
      end

      // compare: flag and pin action from one match
      if (match_event) begin
         next_s.flag = 1'b1;
         case (mode)
            MODE_CMP_SET: begin
               next_s.compare_latch = 1'b1;
            end
            MODE_CMP_CLEAR: begin
               next_s.compare_latch = 1'b0;
            end
            MODE_CMP_SOFT: begin
               next_s.compare_latch = s.compare_latch;
            end
            MODE_CMP_SPECIAL: begin
               next_s.trig.timer_reset = 1'b1;
               next_s.trig.adc_start = adc_enable;
            end
            default: begin
               next_s.compare_latch = s.compare_latch;
            end
         endcase
      end

      // off: compare output falls to its default low
      if (mode == MODE_OFF) begin
         next_s.compare_latch = 1'b0;
      end

      // pin driver: direction bit low means this end drives
      next_s.pin.level = cc_is_compare(mode) ? next_s.compare_latch : port_latch;
      next_s.pin.drive_n = pin_dir_in;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hreadyout = s.ready;
   assign hresp = s.resp;
   assign hrdata = s.rdata;
   assign pin_out = s.pin;
   assign trigger = s.trig;
   assign unit_irq_flag = s.flag;

endmodule

// file: dv/cc_unit_chk.sv
// port assertions of the capture/compare unit
`timescale 1ns/1ps
module cc_unit_chk
   (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic adc_enable,
   input wire cc_pkg::cc_pin_out_type pin_out,
   input wire cc_pkg::cc_trigger_type trigger,
   input wire logic unit_irq_flag
   );
   import cc_pkg::*;
   logic take;
   logic wr_flag_q;
   logic wr_ctl_q;
   logic rd_ctl_q;
   logic [3:0] ctl_q;
   assign take = hsel && htrans[1] && hready;
   // mirror of the mode field, taken when the write data phase ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_flag_q <= 1'b0;
         wr_ctl_q <= 1'b0;
         rd_ctl_q <= 1'b0;
         ctl_q <= MODE_OFF;
      end else begin
         if (hready) begin
            wr_flag_q <= take && hwrite && haddr[9:0] == ADDR_FLAG;
            wr_ctl_q <= take && hwrite && haddr[9:0] == ADDR_CONTROL;
            rd_ctl_q <= take && !hwrite && haddr[9:0] == ADDR_CONTROL;
         end
         if (wr_ctl_q && hready) begin
            ctl_q <= hwdata[3:0];
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_one_a: assert property (!hreadyout |=> hreadyout)
      else $error("read wait longer than one cycle");
   rd_wait_a: assert property (take && !hwrite |=> !hreadyout)
      else $error("read answered without its wait cycle");
   ctl_read_a: assert property ($rose(hreadyout) && $past(rd_ctl_q) |-> hrdata[31:6] == 26'h0)
      else $error("control upper bits read nonzero");
   flag_clear_a: assert property ($fell(unit_irq_flag) |-> $past(wr_flag_q && !hwdata[2]))
      else $error("flag cleared without a software write");
   trig_pulse_a: assert property (trigger.timer_reset |=> !trigger.timer_reset)
      else $error("trigger pulse longer than one cycle");
   trig_mode_a: assert property (trigger.timer_reset |-> $past(ctl_q) == MODE_CMP_SPECIAL)
      else $error("trigger outside special event mode");
   trig_adc_a: assert property (trigger.timer_reset && $stable(adc_enable)
      |-> trigger.adc_start == adc_enable)
      else $error("conversion start does not follow enable");
   trig_flag_a: assert property ($rose(trigger.timer_reset) |-> unit_irq_flag)
      else $error("trigger without the flag");
   set_pin_a: assert property ($rose(unit_irq_flag) && ctl_q == MODE_CMP_SET |=> pin_out.level)
      else $error("pin not driven high on match");
   clr_pin_a: assert property ($rose(unit_irq_flag) && ctl_q == MODE_CMP_CLEAR |=> !pin_out.level)
      else $error("pin not driven low on match");
   soft_pin_a: assert property ($rose(unit_irq_flag) && ctl_q == MODE_CMP_SOFT
      |=> $stable(pin_out.level))
      else $error("pin moved in flag only mode");
   cover property (trigger.timer_reset && !trigger.adc_start);
   cover property (trigger.timer_reset && trigger.adc_start);
   cover property ($rose(unit_irq_flag) && ctl_q == MODE_CAP_RISE16);
   cover property ($rose(hreadyout) && $past(rd_ctl_q));
endmodule
bind cc_unit cc_unit_chk CHK (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .adc_enable(adc_enable), .pin_out(pin_out),
   .trigger(trigger), .unit_irq_flag(unit_irq_flag));

// file: dv/cc_pin_model.sv
// signal source on the shared pin
`timescale 1ns/1ps
module cc_pin_model
   (
   input wire logic hclk,
   input wire logic drive_n,
   input wire logic level,
   output logic pin_in
   );
   logic src = 1'b0;
   // whoever drives wins; the unit only when its enable is low
   assign pin_in = drive_n ? src : level;
   // changes only after a clock edge, as a synchronous source must
   task automatic pulse(input int n);
      repeat (n) begin
         src <= 1'b1;
         repeat (3) @(posedge hclk);
         src <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask
endmodule

// file: dv/cc_unit_bench.sv
// self-checking bench of the capture/compare unit
`timescale 1ns/1ps
module cc_unit_bench;
   import cc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, flag, pin_in;
   logic [31:0] hrdata, r;
   logic [15:0] tcnt = 16'h0;
   logic adc_en = 1'b1, dir_in = 1'b1, latch = 1'b0;
   cc_pin_out_type pin_out;
   cc_trigger_type trigger;
   int fail_count = 0, compares = 0, trig_n = 0, adc_n = 0;
   always #12.5 hclk = ~hclk;
   cc_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_count(tcnt),
      .adc_enable(adc_en), .pin_in(pin_in), .pin_dir_in(dir_in), .port_latch(latch),
      .pin_out(pin_out), .trigger(trigger), .unit_irq_flag(flag));
   cc_pin_model PIN (.hclk(hclk), .drive_n(pin_out.drive_n), .level(pin_out.level),
      .pin_in(pin_in));
   always @(posedge hclk) begin
      trig_n += (trigger.timer_reset === 1'b1);
      adc_n += (trigger.adc_start === 1'b1);
   end
   task automatic end_of_test;
      $display("mismatches %0d of %0d compares", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // single word transfer; read data left in r
   task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic t_regs;
      // outputs straight after reset
      check(flag, 1'b0);
      check(pin_out, 32'h1);
      check(trigger, 32'h0);
      check(hresp, 1'b0);
      check(hrdata, 32'h0);
      bus(ADDR_CONTROL, 1'b0, 32'h0);
      check(r, 32'h0);
      bus(ADDR_CONTROL, 1'b1, 32'hff);
      bus(ADDR_CONTROL, 1'b0, 32'h0);
      check(r, 32'h3f);
      bus(ADDR_VALUE_LOW, 1'b1, 32'h34);
      bus(ADDR_VALUE_HIGH, 1'b1, 32'h12);
      bus(ADDR_VALUE_LOW, 1'b0, 32'h0);
      check(r, 32'h34);
      bus(ADDR_VALUE_HIGH, 1'b0, 32'h0);
      check(r, 32'h12);
      bus(10'h3fc, 1'b1, 32'hff);
      bus(10'h3fc, 1'b0, 32'h0);
      check(r, 32'h0);
      check(flag, 1'b0);
      check(hresp, 1'b0);
   endtask
   task automatic t_capture;
      logic [3:0] m[4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
      int n[4] = '{1, 2, 4, 16};
      for (int i = 0; i < 4; i++) begin
         bus(ADDR_CONTROL, 1'b1, 32'h0);
         bus(ADDR_CONTROL, 1'b1, {28'h0, m[i]});
         bus(ADDR_FLAG, 1'b1, 32'h0);
         for (int k = 0; k < n[i]; k++) begin
            if (k == n[i] - 1 && i != 1)
               check(flag, 1'b0);
            tcnt <= {m[i], 12'h0} + 16'(k);
            PIN.pulse(1);
         end
         check(flag, 1'b1);
         bus(ADDR_VALUE_LOW, 1'b0, 32'h0);
         check(r, {24'h0, tcnt[7:0]});
         bus(ADDR_VALUE_HIGH, 1'b0, 32'h0);
         check(r, {24'h0, tcnt[15:8]});
         bus(ADDR_FLAG, 1'b0, 32'h0);
         check(r, 32'h4);
      end
      // pin turned output: a latch write is an edge too
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      dir_in <= 1'b0;
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CAP_RISE});
      bus(ADDR_FLAG, 1'b1, 32'h0);
      latch <= 1'b1;
      repeat (4) @(posedge hclk);
      check(flag, 1'b1);
      latch <= 1'b0;
      dir_in <= 1'b1;
   endtask
   task automatic t_prescale;
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CAP_RISE16});
      PIN.pulse(3);
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CAP_RISE4});
      bus(ADDR_FLAG, 1'b1, 32'h0);
      @(posedge hclk);
      check(flag, 1'b0);
      PIN.pulse(1);
      check(flag, 1'b1);
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CAP_RISE4});
      bus(ADDR_FLAG, 1'b1, 32'h0);
      PIN.pulse(3);
      check(flag, 1'b0);
      PIN.pulse(1);
      check(flag, 1'b1);
   endtask
   task automatic t_compare;
      logic [3:0] m[4] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLEAR, MODE_CMP_SPECIAL};
      logic e[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      dir_in <= 1'b0;
      bus(ADDR_VALUE_LOW, 1'b1, 32'h78);
      bus(ADDR_VALUE_HIGH, 1'b1, 32'h56);
      for (int i = 0; i < 4; i++) begin
         tcnt <= 16'h5677;
         bus(ADDR_CONTROL, 1'b1, {28'h0, m[i]});
         bus(ADDR_FLAG, 1'b1, 32'h0);
         @(posedge hclk);
         check(flag, 1'b0);
         tcnt <= 16'h5678;
         repeat (4) @(posedge hclk);
         check(flag, 1'b1);
         check(pin_out.level, e[i]);
         check(trig_n, i == 3);
         check(adc_n, i == 3);
      end
      // converter disabled: timer reset without a conversion start
      adc_en <= 1'b0;
      tcnt <= 16'h5677;
      bus(ADDR_FLAG, 1'b1, 32'h0);
      tcnt <= 16'h5678;
      repeat (4) @(posedge hclk);
      check(trig_n, 32'd2);
      check(adc_n, 32'd1);
      check(pin_out.drive_n, 1'b0);
      adc_en <= 1'b1;
      // off clears the compare latch, seen again once back in compare
      tcnt <= 16'h5677;
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CMP_SET});
      tcnt <= 16'h5678;
      repeat (4) @(posedge hclk);
      check(pin_out.level, 1'b1);
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      bus(ADDR_CONTROL, 1'b1, {28'h0, MODE_CMP_SOFT});
      repeat (2) @(posedge hclk);
      check(pin_out.level, 1'b0);
      bus(ADDR_CONTROL, 1'b1, 32'h0);
      dir_in <= 1'b1;
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_capture();
      t_prescale();
      t_compare();
      end_of_test();
   end
endmodule
